// file: logic/cltc_map.svh
/*
  Constants of the closed-loop trim controller: codes, widths, timing.
  Assumes it is included by the design file.
*/
// Contract
// - Each interval, closed-loop channels measure, compare, adjust
// - Setpoint per channel comes from non-volatile storage
// - Compare gives +1, -1 or 0
// - Nonzero result steps trim by one, polarity-aware
// - Zero result keeps trim unchanged
// - Two-bit rate selects 432us/1.06ms/8.74ms/16.9ms
// - Channel n measured only through monitor n
// - Enable low starts all closed-loop channels together
// - Static and host-written channels ignore enable
// - Enable high: finish current cycle, then suspend
// - Suspended DACs keep last code indefinitely
// - Re-enable continues from retained trim values
// - Profile pins not both low suspend loop
// - Profile back to zero with enable resumes
// - Enable tied low starts after power-on
// - Trim registers start at 80h
// - Host writes load the trim register
// - Closed loop only in profile zero, per-channel mode
// - Reset command returns trims to 80h, restarts (code resets closed-loop channels' trims only)
// - Lock reasserts only after post-reset trim completes
`ifndef CLTC_MAP_SVH
`define CLTC_MAP_SVH
`define CLTC_CLK_MHZ 200
`define CLTC_T0_NS 432000
`define CLTC_T1_NS 1060000
`define CLTC_T2_NS 8740000
`define CLTC_T3_NS 16900000
// Divide first: the slowest interval times the clock overflows int
`define CLTC_CYC(ns) (((ns) / 1000) * `CLTC_CLK_MHZ)
`define CLTC_TRIM_RST 8'h80
`define CLTC_TRIM_MIN 8'h00
`define CLTC_TRIM_MAX 8'hFF
`define CLTC_MODE_REG0 2'h0
`define CLTC_MODE_I2C 2'h1
`define CLTC_MODE_CLT 2'h2
`define CLTC_PROF0 2'h0
`endif

// file: logic/cltc_pkg.sv
/*
  Types for the closed-loop trim controller.
  Assumes nothing beyond the map header.
*/
package cltc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_CONV = 4'h4,
    ST_STEP = 4'h8
  } cltc_state_e;
endpackage : cltc_pkg

// file: logic/cltc_trim_ctrl.sv
/*
  Closed-loop trim controller: interval timer, per-channel compare and step of
  the trim registers, pause by enable and profile pins, lock indication.
  Assumes an ADC that converts one monitor per request with a done pulse, and
  setpoints, polarity and mode held stable by non-volatile configuration.
*/
`timescale 1ns/1ps
`include "cltc_map.svh"
module cltc_trim_ctrl #(
  parameter int NCH = 6,
  parameter int AW = 10,
  parameter int T0_CYC = `CLTC_CYC(`CLTC_T0_NS),
  parameter int T1_CYC = `CLTC_CYC(`CLTC_T1_NS),
  parameter int T2_CYC = `CLTC_CYC(`CLTC_T2_NS),
  parameter int T3_CYC = `CLTC_CYC(`CLTC_T3_NS)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic loop_enable_n,
  input wire logic profile_select_lsb,
  input wire logic profile_select_msb,
  input wire logic reset_cmd,
  output logic trim_lock_alert,
  // Configuration
  input wire logic [1:0] update_rate,
  input wire logic [NCH*2-1:0] chan_mode,
  input wire logic [NCH-1:0] chan_polarity,
  input wire logic [NCH*AW-1:0] setpoint,
  // Host preload
  input wire logic host_wr,
  input wire logic [2:0] host_chan,
  input wire logic [7:0] host_data,
  // ADC
  output logic adc_req,
  output logic [2:0] adc_chan,
  input wire logic adc_done,
  input wire logic [AW-1:0] adc_data,
  // Trim codes
  output logic [NCH*8-1:0] trim_code,
  output logic loop_active
);

  localparam int CW = $clog2(T3_CYC + 1);

  typedef struct packed {
    cltc_pkg::cltc_state_e st;
    logic [CW-1:0] tmr;
    logic [2:0] ch;
    logic [1:0] cmp;
    logic lock;
    logic [NCH*8-1:0] trim;
  } cltc_reg_s;

  cltc_reg_s r_q;
  cltc_reg_s r_d;
  logic [1:0] rs_q;
  logic rst_s_n;

  // Two-stage reset release
  // Assertion stays asynchronous; only the release is staged
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_s_n = rs_q[1];

  // One less than the count: the zero state is a cycle of its own
  function automatic logic [CW-1:0] rate_cyc(input logic [1:0] r);
    unique case (r)
      2'h0: rate_cyc = CW'(T0_CYC - 1);
      2'h1: rate_cyc = CW'(T1_CYC - 1);
      2'h2: rate_cyc = CW'(T2_CYC - 1);
      2'h3: rate_cyc = CW'(T3_CYC - 1);
    endcase
  endfunction : rate_cyc

  // Three-valued compare: 01 = +1, 11 = -1, 00 = 0
  function automatic logic [1:0] tri_cmp(input logic [AW-1:0] sp, input logic [AW-1:0] m);
    tri_cmp = (sp > m) ? 2'h1 : ((sp < m) ? 2'h3 : 2'h0);
  endfunction : tri_cmp

  function automatic logic is_clt(input logic [NCH*2-1:0] md, input logic [2:0] c);
    is_clt = (md[c*2 +: 2] == `CLTC_MODE_CLT);
  endfunction : is_clt

  logic run_ok;
  logic any_clt;
  logic [7:0] cur;
  logic up;

  // Loop runs only with enable low and profile zero
  assign run_ok = !loop_enable_n && ({profile_select_msb, profile_select_lsb} == `CLTC_PROF0);

  always_comb begin
    any_clt = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      any_clt = any_clt | (chan_mode[i*2 +: 2] == `CLTC_MODE_CLT);
    end
  end

  assign cur = r_q.trim[r_q.ch*8 +: 8];
  // A set polarity bit inverts the sense of the error
  assign up = (r_q.cmp == 2'h1) ^ chan_polarity[r_q.ch];

  always_comb begin
    r_d = r_q;
    // Host preload; the loop's own step in the same cycle yields to it
    if (host_wr && host_chan < 3'(NCH)) begin
      r_d.trim[host_chan*8 +: 8] = host_data;
    end
    unique case (r_q.st)
      cltc_pkg::ST_IDLE: begin
        // Retained trim values are reused, never reloaded here
        if (run_ok && any_clt) begin
          r_d.st = cltc_pkg::ST_WAIT;
          r_d.tmr = rate_cyc(update_rate);
        end
      end
      cltc_pkg::ST_WAIT: begin
        // Pins are honoured only between passes: here, in idle and at the last channel's step
        if (!run_ok) begin
          r_d.st = cltc_pkg::ST_IDLE;
        end else if (r_q.tmr == '0) begin
          r_d.st = cltc_pkg::ST_CONV;
          r_d.ch = 3'h0;
        end else begin
          r_d.tmr = r_q.tmr - CW'(1);
        end
      end
      cltc_pkg::ST_CONV: begin
        // Pins are not looked at here so the cycle completes
        if (!is_clt(chan_mode, r_q.ch)) begin
          r_d.cmp = 2'h0;
          r_d.st = cltc_pkg::ST_STEP;
        end else if (adc_done) begin
          r_d.cmp = tri_cmp(setpoint[r_q.ch*AW +: AW], adc_data);
          r_d.st = cltc_pkg::ST_STEP;
        end
      end
      cltc_pkg::ST_STEP: begin
        // Saturate, not wrap: a wrap would swing the supply end to end
        if (r_q.cmp != 2'h0 && !(host_wr && host_chan == r_q.ch)) begin
          if (up && cur != `CLTC_TRIM_MAX) begin
            r_d.trim[r_q.ch*8 +: 8] = cur + 8'h01;
          end else if (!up && cur != `CLTC_TRIM_MIN) begin
            r_d.trim[r_q.ch*8 +: 8] = cur - 8'h01;
          end
        end
        if (r_q.ch == 3'(NCH - 1)) begin
          r_d.lock = 1'b1;
          r_d.st = run_ok ? cltc_pkg::ST_WAIT : cltc_pkg::ST_IDLE;
          r_d.tmr = rate_cyc(update_rate);
        end else begin
          r_d.ch = r_q.ch + 3'h1;
          r_d.st = cltc_pkg::ST_CONV;
        end
      end
      default: r_d.st = cltc_pkg::ST_IDLE;
    endcase
    // Reset command: closed-loop trims back to bipolar zero, lock drops until a full pass
    if (reset_cmd) begin
      r_d.st = cltc_pkg::ST_IDLE;
      r_d.lock = 1'b0;
      r_d.tmr = '0;
      r_d.ch = 3'h0;
      r_d.cmp = 2'h0;
      for (int i = 0; i < NCH; i++) begin
        if (chan_mode[i*2 +: 2] == `CLTC_MODE_CLT) begin
          r_d.trim[i*8 +: 8] = `CLTC_TRIM_RST;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      r_q.st <= cltc_pkg::ST_IDLE;
      r_q.tmr <= '0;
      r_q.ch <= 3'h0;
      r_q.cmp <= 2'h0;
      r_q.lock <= 1'b0;
      r_q.trim <= {NCH{`CLTC_TRIM_RST}};
    end else begin
      r_q <= r_d;
    end
  end

  // Codes hold whatever they last were while suspended
  assign trim_code = r_q.trim;
  assign trim_lock_alert = r_q.lock;
  assign adc_req = (r_q.st == cltc_pkg::ST_CONV) && is_clt(chan_mode, r_q.ch);
  assign adc_chan = r_q.ch;
  assign loop_active = (r_q.st != cltc_pkg::ST_IDLE);

  // Host and reset strobes win over the loop, so checks step aside for them
  property p_start;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_IDLE && run_ok && any_clt && !reset_cmd)
      |=> r_q.st == cltc_pkg::ST_WAIT;
  endproperty
  a_start: assert property (p_start) else $error("loop did not start");

  property p_pause;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_WAIT && !run_ok && !reset_cmd) |=> r_q.st == cltc_pkg::ST_IDLE;
  endproperty
  a_pause: assert property (p_pause) else $error("loop not suspended");

  property p_zero_hold;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.cmp == 2'h0 && !host_wr && !reset_cmd)
      |=> $stable(trim_code);
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("trim moved on zero");

  property p_idle_hold;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_IDLE && !host_wr && !reset_cmd) |=> $stable(trim_code);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("trim moved while idle");

  property p_reset_cmd;
    @(posedge clk_sys) disable iff (!rst_s_n)
      reset_cmd |=> !trim_lock_alert && r_q.st == cltc_pkg::ST_IDLE;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");

  property p_lock;
    @(posedge clk_sys) disable iff (!rst_s_n)
      $rose(trim_lock_alert) |-> $past(r_q.st) == cltc_pkg::ST_STEP;
  endproperty
  a_lock: assert property (p_lock) else $error("lock without completed pass");

  property p_step_one;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.cmp != 2'h0 && !host_wr && !reset_cmd && up
       && cur != `CLTC_TRIM_MAX) |=> trim_code[$past(r_q.ch)*8 +: 8] == $past(cur) + 8'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("trim step not one");

  property p_host;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (host_wr && host_chan < 3'(NCH) && !reset_cmd)
      |=> trim_code[$past(host_chan)*8 +: 8] == $past(host_data);
  endproperty
  a_host: assert property (p_host) else $error("host preload lost");

  property p_adc_chan;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (adc_req && adc_done && !reset_cmd)
      |=> r_q.cmp == tri_cmp($past(setpoint[adc_chan*AW +: AW]), $past(adc_data));
  endproperty
  a_adc_chan: assert property (p_adc_chan) else $error("wrong monitor");

  property p_adc_hold;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (adc_req && !adc_done && !reset_cmd) |=> adc_req && adc_chan == $past(adc_chan);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("monitor request dropped");

  property p_step_down;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.cmp != 2'h0 && !host_wr && !reset_cmd && !up
       && cur != `CLTC_TRIM_MIN) |=> trim_code[$past(r_q.ch)*8 +: 8] == $past(cur) - 8'h01;
  endproperty
  a_step_down: assert property (p_step_down) else $error("trim step down not one");

  property p_sat_max;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.cmp != 2'h0 && !host_wr && !reset_cmd && up
       && cur == `CLTC_TRIM_MAX) |=> trim_code[$past(r_q.ch)*8 +: 8] == `CLTC_TRIM_MAX;
  endproperty
  a_sat_max: assert property (p_sat_max) else $error("trim wrapped above max");

  property p_sat_min;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.cmp != 2'h0 && !host_wr && !reset_cmd && !up
       && cur == `CLTC_TRIM_MIN) |=> trim_code[$past(r_q.ch)*8 +: 8] == `CLTC_TRIM_MIN;
  endproperty
  a_sat_min: assert property (p_sat_min) else $error("trim wrapped below min");

  property p_static;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && !is_clt(chan_mode, r_q.ch) && !host_wr && !reset_cmd)
      |=> $stable(trim_code);
  endproperty
  a_static: assert property (p_static) else $error("static channel stepped");

  property p_finish;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_CONV && !reset_cmd)
      |=> r_q.st == cltc_pkg::ST_CONV || r_q.st == cltc_pkg::ST_STEP;
  endproperty
  a_finish: assert property (p_finish) else $error("pass cut short");

  property p_tmr;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_WAIT && run_ok && r_q.tmr != '0 && !reset_cmd)
      |=> r_q.st == cltc_pkg::ST_WAIT && r_q.tmr == $past(r_q.tmr) - CW'(1);
  endproperty
  a_tmr: assert property (p_tmr) else $error("interval count skipped");

  property p_reload;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.ch == 3'(NCH - 1) && run_ok && !reset_cmd)
      |=> r_q.st == cltc_pkg::ST_WAIT && r_q.tmr == rate_cyc($past(update_rate));
  endproperty
  a_reload: assert property (p_reload) else $error("interval not reloaded");

  property p_reset_trim;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (reset_cmd && is_clt(chan_mode, 3'h0)) |=> trim_code[7:0] == `CLTC_TRIM_RST;
  endproperty
  a_reset_trim: assert property (p_reset_trim) else $error("trim not reset");

  property p_lock_hold;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (trim_lock_alert && !reset_cmd) |=> trim_lock_alert;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped by pause");

  property p_ch_order;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_STEP && r_q.ch != 3'(NCH - 1) && !reset_cmd)
      |=> r_q.st == cltc_pkg::ST_CONV && r_q.ch == $past(r_q.ch) + 3'h1;
  endproperty
  a_ch_order: assert property (p_ch_order) else $error("channel skipped");

  property p_host_range;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_IDLE && host_wr && host_chan >= 3'(NCH) && !reset_cmd)
      |=> $stable(trim_code);
  endproperty
  a_host_range: assert property (p_host_range) else $error("write to absent channel");

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (!rst_s_n)
      (r_q.st == cltc_pkg::ST_IDLE && !reset_cmd && !(run_ok && any_clt)) |=> !loop_active;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("left idle while paused");

endmodule : cltc_trim_ctrl

// file: testbench/cltc_adc_model.sv
/*
  Supply monitor ADC model for the trim controller bench.
  Assumes each request is held until done; monitor n reads 1FF plus (n mod 3).
*/
`timescale 1ns/1ps
module cltc_adc_model (
  // Clock
  input wire logic clk_sys,
  // Pacing
  input wire logic slow,
  // Conversion
  input wire logic adc_req,
  input wire logic [2:0] adc_chan,
  output logic adc_done,
  output logic [9:0] adc_data
);
  int cnt = 0;
  logic [9:0] last_q = 10'h000;
  initial adc_done = 1'b0;
  initial adc_data = 10'h3FF;
  always @(posedge clk_sys) begin
    adc_done <= 1'b0;
    // Never left looking valid outside done
    adc_data <= ~last_q;
    if (adc_req && !adc_done) begin
      if (cnt >= (slow ? 5 : 1)) begin
        cnt <= 0;
        adc_done <= 1'b1;
        last_q <= 10'h1FF + 10'(adc_chan % 3);
        adc_data <= 10'h1FF + 10'(adc_chan % 3);
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : cltc_adc_model

// file: testbench/closed_loop_trim_control_test.sv
/*
  Self-checking bench for the closed-loop trim controller.
  Assumes the ADC model beside it and shortened interval counts 20/30/40/50.
*/
`timescale 1ns/1ps
module closed_loop_trim_control_test;
  typedef struct {
    logic [1:0] rate;
    logic [5:0] pol;
    logic [11:0] mode;
    logic [47:0] exp;
  } cltc_row_s;
  cltc_row_s rows [4];
  logic clk_sys = 0, rst_n = 0, en_n = 0, lsb = 0, msb = 0, rcmd = 0, hwr = 0;
  logic [1:0] rate = 2'h0;
  logic [11:0] mode = 12'hAAA;
  logic [5:0] pol = 6'h00;
  logic [59:0] sp = {6{10'h200}};
  logic [2:0] hch = 3'h0, adc_chan;
  logic [7:0] hdat = 8'h00;
  logic [47:0] trim_code;
  logic lock, adc_req, adc_done, active;
  logic req0_q = 0;
  logic [9:0] adc_data;
  int n_fail = 0, checks = 0, cyc = 0, t5 = 0, gap = 0, nrise = 0;
  initial forever #2.5 clk_sys = ~clk_sys;
  cltc_trim_ctrl #(.T0_CYC(20), .T1_CYC(30), .T2_CYC(40), .T3_CYC(50)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .loop_enable_n(en_n), .profile_select_lsb(lsb),
    .profile_select_msb(msb), .reset_cmd(rcmd), .trim_lock_alert(lock), .update_rate(rate),
    .chan_mode(mode), .chan_polarity(pol), .setpoint(sp), .host_wr(hwr),
    .host_chan(hch), .host_data(hdat), .adc_req(adc_req), .adc_chan(adc_chan),
    .adc_done(adc_done), .adc_data(adc_data), .trim_code(trim_code), .loop_active(active));
  cltc_adc_model u_adc (.clk_sys(clk_sys), .slow(rate[0]), .adc_req(adc_req),
    .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
  // Falling edge: comb request has settled
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    if (adc_done && adc_chan == 3'h5) t5 <= cyc;
    if (adc_req && adc_chan == 3'h0 && !req0_q) begin
      gap <= cyc - t5;
      nrise <= nrise + 1;
    end
    req0_q <= adc_req && adc_chan == 3'h0;
  end
  task check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Ends as pass n+1 starts, so n passes are complete
  task passes(input int n);
    int tgt;
    tgt = nrise + n + 1;
    for (int i = 0; i < 9000 && nrise < tgt; i++) @(posedge clk_sys);
  endtask : passes
  task hold(input logic [47:0] exp);
    tick(400);
    #1;
    check(trim_code, exp);
    check(48'(active), 48'h0);
  endtask : hold
  task give_verdict();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end
  initial begin
    rows[0] = '{2'h0, 6'h00, 12'hAAA, 48'h7D_80_83_7D_80_83};
    rows[1] = '{2'h1, 6'h3F, 12'hAAA, 48'h83_80_7D_83_80_7D};
    rows[2] = '{2'h2, 6'h05, 12'hA1A, 48'h7D_80_7C_84_80_7D};
    rows[3] = '{2'h3, 6'h00, 12'hAAA, 48'h7D_80_83_7D_80_83};
    tick(5);
    rst_n <= 1'b1;
    #1;
    check(trim_code, {6{8'h80}});
    check(48'(lock), 48'h0);
    passes(0);
    #1;
    check(48'({adc_req, adc_chan}), 48'h8);
    $display("test power-on done");
    foreach (rows[i]) begin
      tick(1);
      en_n <= 1'b1;
      tick(400);
      rate <= rows[i].rate;
      pol <= rows[i].pol;
      mode <= rows[i].mode;
      rcmd <= 1'b1;
      tick(1);
      rcmd <= 1'b0;
      en_n <= 1'b0;
      passes(3);
      #1;
      check(trim_code, rows[i].exp);
      check(48'(gap >= 20 + 10 * int'(rows[i].rate) && gap <= 23 + 10 * int'(rows[i].rate)),
        48'h1);
      $display("test row %0d done", i);
    end
    // Pass in progress when paused still lands
    tick(1);
    en_n <= 1'b1;
    hold(48'h7C_80_84_7C_80_84);
    hold(48'h7C_80_84_7C_80_84);
    tick(1);
    en_n <= 1'b0;
    passes(1);
    #1;
    check(trim_code, 48'h7B_80_85_7B_80_85);
    tick(1);
    lsb <= 1'b1;
    hold(48'h7A_80_86_7A_80_86);
    tick(1);
    lsb <= 1'b0;
    msb <= 1'b1;
    hold(48'h7A_80_86_7A_80_86);
    tick(1);
    msb <= 1'b0;
    passes(1);
    #1;
    check(trim_code, 48'h79_80_87_79_80_87);
    $display("test pause done");
    tick(1);
    en_n <= 1'b1;
    hold(48'h78_80_88_78_80_88);
    tick(1);
    hwr <= 1'b1;
    hdat <= 8'hFE;
    tick(1);
    hch <= 3'h2;
    hdat <= 8'h01;
    tick(1);
    hch <= 3'h7;
    hdat <= 8'h55;
    tick(1);
    hwr <= 1'b0;
    en_n <= 1'b0;
    passes(3);
    #1;
    check(trim_code, 48'h75_80_8B_00_80_FF);
    $display("test preload done");
    tick(1);
    rcmd <= 1'b1;
    tick(1);
    rcmd <= 1'b0;
    #1;
    check(trim_code, {6{8'h80}});
    check(48'(lock), 48'h0);
    passes(1);
    #1;
    check(48'(lock), 48'h1);
    $display("test reset command done");
    // Mid-run reset; two monitors get setpoints off their readings
    tick(1);
    rst_n <= 1'b0;
    sp <= {10'h200, 10'h1FE, 10'h200, 10'h200, 10'h201, 10'h200};
    tick(2);
    #1;
    check(trim_code, {6{8'h80}});
    check(48'({lock, active, adc_req}), 48'h0);
    tick(1);
    rst_n <= 1'b1;
    passes(2);
    #1;
    check(trim_code, 48'h7E_7E_82_7E_82_82);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : closed_loop_trim_control_test
